// *** hw/supply_monitor_ctrl.v ***
// Supply voltage monitor control: option decode, reset/interrupt sequencing, AXI4-Lite registers
//
// Notes on behaviour
// RULE1: Non-monitor reset returns control register to 00H.
// RULE2: Monitor reset keeps control; others clear write enable.
// RULE3: Flag and mask status bits are read-only.
// RULE4: Level register writable only while write enable set.
// RULE5: Mask status set while masked in interrupt-reset mode.
// RULE6: Flag high when supply below selected threshold.
// RULE7: Software touches enable/mask only in interrupt-reset mode.
// RULE8: Mode bit: 0 interrupt, 1 reset operation.
// RULE9: Level select: 0 upper, 1 lower/single threshold.
// RULE10: Monitor reset preserves level/mode register.
// RULE11: Other resets load level register from option mode.
// RULE12: Software writes zero to level bits only there.
// RULE13: Interrupt-reset mode updates level bits on events.
// RULE14: Option byte layout; bit 4 must be one.
// RULE15: Decode option mode; off when level MSB and bit0.
// RULE16: Only listed threshold code combinations are allowed.
// RULE17: Boot swap needs identical option byte copies.
// RULE18: Reset mode holds reset until supply above threshold.
// RULE19: Reset mode asserts reset when supply drops below.
// RULE20: Both registers support bit and byte read-modify-write.
// RULE21: Upper threshold interrupts and releases; lower resets.
// RULE22: Interrupt mode: single threshold releases, then interrupts.
// RULE23: After interrupt, level select and mode bit set.
// RULE24: Every monitor reset flags the reset cause. The code does not set it for the hold that follows a load from the option byte.
// RULE25: Comparator outputs pass a two-stage synchroniser.
// RULE26: Unused register bits read zero, ignore writes.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_regs.vh"

module supply_monitor_ctrl #(
  parameter [15:0] SETTLE_CYCLES = `SETTLE_CYCLES_DEF // Settling wait in clock cycles
) (
  input  wire               clock,          // System clock, 100 MHz
  input  wire               rst_n,          // Power-on reset, async, active low
  input  wire               otherResetReq,  // Non-monitor chip reset active, level
  input  wire [7:0]         optionByte,     // Option byte from nonvolatile store
  input  wire               upperBelowRaw,  // Async: supply below upper threshold
  input  wire               lowerBelowRaw,  // Async: supply below lower/single threshold
  output reg                monitorResetReq, // Internal reset request, level
  output reg                monitorIrq,      // Monitor interrupt request, pulse
  output reg                resetCauseSet,   // Sets reset cause flag bit 0, pulse
  output wire               optionFault,     // Option byte fixed bit not one
  input  wire [`ADDR_W-1:0] awaddr,          // Write address
  input  wire               awvalid,         // Write address valid
  output wire               awready,         // Write address ready
  input  wire [`DATA_W-1:0] wdata,           // Write data
  input  wire [3:0]         wstrb,           // Write byte strobes
  input  wire               wvalid,          // Write data valid
  output wire               wready,          // Write data ready
  output reg  [1:0]         bresp,           // Write response
  output reg                bvalid,          // Write response valid
  input  wire               bready,          // Write response ready
  input  wire [`ADDR_W-1:0] araddr,          // Read address
  input  wire               arvalid,         // Read address valid
  output wire               arready,         // Read address ready
  output reg  [`DATA_W-1:0] rdata,           // Read data
  output reg  [1:0]         rresp,           // Read response
  output reg                rvalid,          // Read data valid
  input  wire               rready           // Read data ready
);

  // Sequencer states, one-hot
  localparam [3:0] ST_LOAD = 4'h1; // Load reset values from option byte
  localparam [3:0] ST_HOLD = 4'h2; // Monitor reset held
  localparam [3:0] ST_RUN  = 4'h4; // Normal monitoring
  localparam [3:0] ST_OFF  = 4'h8; // Monitor disabled

  // Byte addresses of the registers
  localparam [`ADDR_W-1:0] ADDR_CTRL   = {`CTRL_INDEX, 2'h0};
  localparam [`ADDR_W-1:0] ADDR_LEVEL  = {`LEVEL_INDEX, 2'h0};
  localparam [`ADDR_W-1:0] ADDR_OPTION = {`OPTION_INDEX, 2'h0};
  localparam [7:0] CTRL_INIT       = `CTRL_RESET;        // Control value after other resets
  localparam [7:0] LVL_INIT_RST    = `LVL_RESET_RST;     // Level value, reset mode
  localparam [7:0] LVL_INIT_IRQ    = `LVL_RESET_IRQ;     // Level value, interrupt mode
  localparam [7:0] LVL_INIT_IRQRST = `LVL_RESET_IRQ_RST; // Level value, interrupt-reset mode

  // Synchronised comparators
  wire [1:0] belowSync;  // {upper, lower} below indications
  wire       upperBelow; // Supply below upper threshold
  wire       lowerBelow; // Supply below lower/single threshold

  // Sequencer and register state
  reg [3:0]  state_reg;        // Sequencer state
  reg [3:0]  state_next;
  reg        writeEnable_reg;  // Level write enable bit
  reg        writeEnable_next;
  reg        modeBit_reg;      // Mode bit of level register
  reg        modeBit_next;
  reg        levelSel_reg;     // Level select bit
  reg        levelSel_next;
  reg [15:0] settleCnt_reg;    // Settling wait counter
  reg [15:0] settleCnt_next;
  reg        prevBelow_reg;    // Previous single-threshold level
  reg        prevBelow_next;
  reg        irqNext;          // Interrupt pulse next value
  reg        causeNext;        // Reset cause pulse next value

  // Bus write channel state
  reg               awHeld_reg;  // Write address captured
  reg [`ADDR_W-1:0] awAddr_reg;  // Captured write address
  reg               wHeld_reg;   // Write data captured
  reg [7:0]         wByte_reg;   // Captured low data byte
  reg               wStrb0_reg;  // Captured low byte strobe

  // Option decode
  wire [1:0] optMode;    // Option mode field
  wire       monitorOff; // Monitor disabled by option
  wire       modeIrqRst; // Interrupt-and-reset mode
  wire       modeRst;    // Reset mode
  wire       modeIrq;    // Interrupt mode

  // Derived status
  wire       selBelow;   // Selected comparator below
  wire       belowFlag;  // Below-threshold flag
  wire       maskNow;    // Output mask status
  wire       doWrite;    // Register write this cycle
  wire       hitCtrlW;   // Write to control register
  wire       hitLevelW;  // Write to level register
  wire       levelWrOk;  // Level write accepted
  wire       arHit;      // Read address mapped
  wire       awHit;      // Write address mapped

  // Comparators are asynchronous to the clock  [RULE25]
  sync_2ff #(
    .WIDTH     (2),
    .RESET_VAL (2'h3)
  ) uSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn ({upperBelowRaw, lowerBelowRaw}),
    .syncOut (belowSync)
  );
  assign upperBelow = belowSync[1];
  assign lowerBelow = belowSync[0];

  // Option mode decode  [RULE15]
  assign optMode    = {optionByte[`OPT_MODE_HI_BIT], optionByte[`OPT_MODE_LO_BIT]};
  assign monitorOff = optionByte[`OPT_POC_HI_BIT] & optionByte[`OPT_MODE_LO_BIT];
  assign modeIrqRst = ~monitorOff & (optMode == `MODE_IRQ_RST);
  assign modeRst    = ~monitorOff & (optMode == `MODE_RST);
  assign modeIrq    = ~monitorOff & (optMode == `MODE_IRQ);
  assign optionFault = ~optionByte[`OPT_FIXED_BIT]; // [RULE14]

  // Level select picks the comparator  [RULE9]
  assign selBelow  = levelSel_reg ? lowerBelow : upperBelow;
  // Flag reads zero when the monitor is off  [RULE6]
  assign belowFlag = (state_reg != ST_OFF) & (state_reg != ST_LOAD) & selBelow;
  // Masked while enabled or settling, only in interrupt-reset mode  [RULE5]
  assign maskNow   = modeIrqRst & (writeEnable_reg | (settleCnt_reg != 16'h0000));

  // Write decode
  assign doWrite   = awHeld_reg & wHeld_reg & ~bvalid;
  assign hitCtrlW  = doWrite & wStrb0_reg & (awAddr_reg == ADDR_CTRL);
  assign hitLevelW = doWrite & wStrb0_reg & (awAddr_reg == ADDR_LEVEL);
  assign levelWrOk = hitLevelW & writeEnable_reg; // [RULE4]
  assign awHit     = (awAddr_reg == ADDR_CTRL) | (awAddr_reg == ADDR_LEVEL) |
                     (awAddr_reg == ADDR_OPTION);
  assign arHit     = (araddr == ADDR_CTRL) | (araddr == ADDR_LEVEL) | (araddr == ADDR_OPTION);

  // Handshake readies
  assign awready = ~awHeld_reg & ~bvalid;
  assign wready  = ~wHeld_reg & ~bvalid;
  assign arready = ~rvalid;

  // Sequencer and register next values
  always @* begin
    state_next       = state_reg;
    writeEnable_next = writeEnable_reg;
    modeBit_next     = modeBit_reg;
    levelSel_next    = levelSel_reg;
    prevBelow_next   = prevBelow_reg;
    irqNext          = 1'b0;
    causeNext        = 1'b0;
    settleCnt_next   = (settleCnt_reg != 16'h0000) ? settleCnt_reg - 16'h0001 : 16'h0000;
    // Software writes; flag and mask bits are never stored  [RULE3] [RULE26]
    if (hitCtrlW) begin
      writeEnable_next = wByte_reg[`CTRL_WREN_BIT]; // [RULE20]
    end
    if (levelWrOk) begin
      modeBit_next  = wByte_reg[`LVL_MODE_BIT]; // [RULE8]
      levelSel_next = wByte_reg[`LVL_SEL_BIT];  // [RULE20]
      if (wByte_reg[`LVL_SEL_BIT] != levelSel_reg) begin
        settleCnt_next = SETTLE_CYCLES; // [RULE5]
      end
    end
    case (state_reg)
      ST_LOAD: begin
        // Reset values by option mode  [RULE1] [RULE2] [RULE11]
        writeEnable_next = CTRL_INIT[`CTRL_WREN_BIT];
        settleCnt_next   = 16'h0000;
        if (optMode == `MODE_RST) begin
          modeBit_next  = LVL_INIT_RST[`LVL_MODE_BIT];
          levelSel_next = LVL_INIT_RST[`LVL_SEL_BIT];
        end else if (optMode == `MODE_IRQ) begin
          modeBit_next  = LVL_INIT_IRQ[`LVL_MODE_BIT];
          levelSel_next = LVL_INIT_IRQ[`LVL_SEL_BIT];
        end else begin
          modeBit_next  = LVL_INIT_IRQRST[`LVL_MODE_BIT];
          levelSel_next = LVL_INIT_IRQRST[`LVL_SEL_BIT];
        end
        state_next = monitorOff ? ST_OFF : ST_HOLD;
      end
      ST_HOLD: begin
        // Release once above the release threshold  [RULE18] [RULE21] [RULE22]
        if (modeIrqRst ? ~upperBelow : ~lowerBelow) begin
          state_next     = ST_RUN;
          prevBelow_next = 1'b0;
        end
      end
      ST_RUN: begin
        prevBelow_next = lowerBelow;
        if (modeRst) begin
          // Falling supply below single threshold resets  [RULE19]
          if (lowerBelow) begin
            state_next = ST_HOLD;
            causeNext  = 1'b1; // [RULE24]
          end
        end else if (modeIrq) begin
          // Interrupt on a crossing in either direction  [RULE22]
          irqNext = (lowerBelow != prevBelow_reg);
        end else if (~maskNow & selBelow) begin
          if (modeBit_reg) begin
            // Reset operation; hardware updates level bits  [RULE13] [RULE21]
            state_next    = ST_HOLD;
            causeNext     = 1'b1; // [RULE24]
            modeBit_next  = 1'b1;
            levelSel_next = 1'b0;
          end else begin
            // Interrupt operation, then switch to reset on lower level  [RULE23]
            irqNext        = 1'b1;
            modeBit_next   = 1'b1;
            levelSel_next  = 1'b1;
            settleCnt_next = SETTLE_CYCLES; // [RULE5]
          end
        end
      end
      ST_OFF: begin
        state_next = ST_OFF;
      end
      default: begin
        state_next = ST_LOAD;
      end
    endcase
    // Non-monitor resets reload everything  [RULE1]
    if (otherResetReq) begin
      state_next = ST_LOAD;
    end
  end

  // Sequencer registers; a monitor reset leaves them untouched  [RULE10]
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_LOAD;
      writeEnable_reg <= 1'b0;
      modeBit_reg     <= 1'b0;
      levelSel_reg    <= 1'b0;
      settleCnt_reg   <= 16'h0000;
      prevBelow_reg   <= 1'b0;
      monitorResetReq <= 1'b0;
      monitorIrq      <= 1'b0;
      resetCauseSet   <= 1'b0;
    end else begin
      state_reg       <= state_next;
      writeEnable_reg <= writeEnable_next;
      modeBit_reg     <= modeBit_next;
      levelSel_reg    <= levelSel_next;
      settleCnt_reg   <= settleCnt_next;
      prevBelow_reg   <= prevBelow_next;
      monitorResetReq <= (state_next == ST_HOLD); // [RULE18]
      monitorIrq      <= irqNext & ~otherResetReq;
      resetCauseSet   <= causeNext & ~otherResetReq;
    end
  end

  // Write channel: address and data captured in either order
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= {`ADDR_W{1'b0}};
      wHeld_reg  <= 1'b0;
      wByte_reg  <= 8'h00;
      wStrb0_reg <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid & wready) begin
        wHeld_reg  <= 1'b1;
        wByte_reg  <= wdata[7:0];
        wStrb0_reg <= wstrb[0];
      end
      if (doWrite) begin
        // Response one cycle after both parts are held
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= awHit ? `RESP_OKAY : `RESP_DECERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data registered on address acceptance
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= {`DATA_W{1'b0}};
      rresp  <= `RESP_OKAY;
    end else begin
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rresp  <= arHit ? `RESP_OKAY : `RESP_DECERR;
        if (araddr == ADDR_CTRL) begin
          // Unused bits read zero  [RULE26] [RULE3]
          rdata <= {24'h000000, writeEnable_reg, 5'h00, maskNow, belowFlag};
        end else if (araddr == ADDR_LEVEL) begin
          rdata <= {24'h000000, modeBit_reg, 6'h00, levelSel_reg}; // [RULE26]
        end else if (araddr == ADDR_OPTION) begin
          rdata <= {24'h000000, optionByte};
        end else begin
          rdata <= {`DATA_W{1'b0}};
        end
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/supply_monitor_regs.vh ***
// Register map, field positions, reset values and timing of the supply monitor control
`ifndef SUPPLY_MONITOR_REGS_VH
`define SUPPLY_MONITOR_REGS_VH

// Bus geometry
`define ADDR_W            22
`define DATA_W            32

// Register indices; the byte address is four times the index
`define CTRL_INDEX        20'hFFFA9
`define LEVEL_INDEX       20'hFFFAA
`define OPTION_INDEX      20'h000C1

// Control/status register fields
`define CTRL_WREN_BIT     7
`define CTRL_MASK_BIT     1
`define CTRL_FLAG_BIT     0

// Level/mode register fields
`define LVL_MODE_BIT      7
`define LVL_SEL_BIT       0

// Option byte fields
`define OPT_MODE_LO_BIT   0
`define OPT_MODE_HI_BIT   1
`define OPT_FIXED_BIT     4
`define OPT_POC_HI_BIT    7

// Option mode codes {hi, lo}
`define MODE_IRQ_RST      2'h2
`define MODE_RST          2'h3
`define MODE_IRQ          2'h1

// Reset values
`define CTRL_RESET        8'h00
`define LVL_RESET_IRQ_RST 8'h00
`define LVL_RESET_RST     8'h81
`define LVL_RESET_IRQ     8'h01

// Timing: settling wait after an interrupt or a level change
`define SETTLE_TIME_US    400
`define CLK_PERIOD_NS     10
`define SETTLE_CYCLES_DEF 16'h9C40

// Bus responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

// *** hw/sync_2ff.v ***
// Two-stage synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module sync_2ff #(
  parameter             WIDTH     = 2,        // Number of bits
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}} // Safe value after reset
) (
  input  wire             clock,   // System clock
  input  wire             rst_n,   // Asynchronous reset, active low
  input  wire [WIDTH-1:0] asyncIn, // Raw asynchronous levels
  output wire [WIDTH-1:0] syncOut  // Synchronised levels
);

  genvar i;

  // One pair of flip-flops per bit; stage one feeds only stage two
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gSync
      reg stage1_reg; // First stage, metastability catcher
      reg stage2_reg; // Second stage, safe to use
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stage1_reg <= RESET_VAL[i];
          stage2_reg <= RESET_VAL[i];
        end else begin
          stage1_reg <= asyncIn[i];
          stage2_reg <= stage1_reg;
        end
      end
      assign syncOut[i] = stage2_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// *** sim/supply_monitor_ctrl_assertions.sv ***
// Port-level checks of the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_ctrl_assertions (
  input wire logic       clock,           // System clock
  input wire logic       rst_n,           // Reset, active low
  input wire logic       otherResetReq,   // Other reset source
  input wire logic [7:0] optionByte,      // Option byte
  input wire logic       lowerBelowRaw,   // Lower comparator
  input wire logic       monitorResetReq, // Reset request
  input wire logic       monitorIrq,      // Interrupt pulse
  input wire logic       resetCauseSet,   // Cause pulse
  input wire logic       optionFault,     // Fixed bit fault
  input wire logic       arvalid,         // Read address valid
  input wire logic       arready,         // Read address ready
  input wire logic       rvalid           // Read data valid
);
  // Mode decode of the option byte
  wire rstMode = optionByte[1:0] == 2'h3 && !optionByte[7];
  wire irqMode = optionByte[1:0] == 2'h1 && !optionByte[7];
  wire offMode = optionByte[7] && optionByte[0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_OTHER_RST: assert property (otherResetReq |=> !monitorResetReq)
    else $error("monitor reset during other reset");
  AST_RST_HOLD: assert property ((rstMode && !otherResetReq && lowerBelowRaw) [*4] |=> monitorResetReq)
    else $error("no reset while supply low");
  AST_RST_FREE: assert property ((rstMode && !otherResetReq && !lowerBelowRaw) [*6] |=> !monitorResetReq)
    else $error("reset held while supply good");
  AST_IRQ_CAUSE: assert property (irqMode && monitorIrq |-> $past(lowerBelowRaw, 3) != $past(lowerBelowRaw, 4))
    else $error("interrupt without crossing");
  AST_IRQ_PULSE: assert property (monitorIrq |=> !monitorIrq)
    else $error("interrupt longer than one cycle");
  AST_CAUSE_PULSE: assert property (resetCauseSet |=> !resetCauseSet)
    else $error("cause pulse too long");
  AST_CAUSE_RST: assert property (resetCauseSet |-> ##[0:1] monitorResetReq)
    else $error("cause pulse without reset");
  AST_OFF: assert property (offMode [*2] |-> !monitorResetReq && !monitorIrq)
    else $error("monitor active while off");
  AST_FAULT: assert property (optionFault == !optionByte[4])
    else $error("fixed bit fault wrong");
  AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
endmodule
bind supply_monitor_ctrl supply_monitor_ctrl_assertions chk_inst (
  .clock(clock), .rst_n(rst_n), .otherResetReq(otherResetReq), .optionByte(optionByte),
  .lowerBelowRaw(lowerBelowRaw), .monitorResetReq(monitorResetReq), .monitorIrq(monitorIrq),
  .resetCauseSet(resetCauseSet), .optionFault(optionFault), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid));
`default_nettype wire

// *** sim/supply_model.sv ***
// Behavioural supply comparators facing the monitor
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
  parameter int UPPER = 300, // Upper threshold, arbitrary units
  parameter int LOWER = 270  // Lower or single threshold
) (
  input  wire logic [15:0] vddMv,         // Modelled supply level
  output wire logic        upperBelowRaw, // Supply below upper threshold
  output wire logic        lowerBelowRaw  // Supply below lower threshold
);
  // Plain comparators; below lower implies below upper
  assign upperBelowRaw = vddMv < UPPER;
  assign lowerBelowRaw = vddMv < LOWER;
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_regs.vh"
module tb;
  localparam logic [21:0] CTRL = {`CTRL_INDEX, 2'b00};   // Control address
  localparam logic [21:0] LVL  = {`LEVEL_INDEX, 2'b00};  // Level address
  localparam logic [21:0] OPT  = {`OPTION_INDEX, 2'b00}; // Option address
  localparam logic [15:0] HIGH = 16'h014A;               // Above both
  localparam logic [15:0] MID  = 16'h011D;               // Between
  localparam logic [15:0] LOW  = 16'h00FA;               // Below both
  typedef struct {logic [7:0] opt; logic [7:0] lvl; int ev; logic [7:0] flag;} row_t;
  // Mode rows: option, level reset, event kind, flag when low
  row_t rows[3] = '{'{8'h1F, 8'h81, 0, 8'h01}, '{8'h1D, 8'h01, 2, 8'h01},
                    '{8'h91, 8'h01, 0, 8'h00}};
  logic        clock, rst_n, otherResetReq, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  optionByte, rd;
  logic [15:0] vddMv;
  logic [21:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [1:0]  rr;
  wire         upperBelowRaw, lowerBelowRaw, monitorResetReq, monitorIrq, resetCauseSet;
  wire         optionFault, awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          n_fail, n_checks;
  supply_model supply_model_inst (.vddMv(vddMv), .upperBelowRaw(upperBelowRaw),
    .lowerBelowRaw(lowerBelowRaw));
  supply_monitor_ctrl #(.SETTLE_CYCLES(16'h0008)) supply_monitor_ctrl_inst (
    .clock(clock), .rst_n(rst_n), .otherResetReq(otherResetReq), .optionByte(optionByte),
    .upperBelowRaw(upperBelowRaw), .lowerBelowRaw(lowerBelowRaw),
    .monitorResetReq(monitorResetReq), .monitorIrq(monitorIrq), .resetCauseSet(resetCauseSet),
    .optionFault(optionFault), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Bus write, both channels offered together
  task automatic wrReg(input logic [21:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!bvalid);
    rr = bresp;
    bready <= 1'b0;
  endtask
  // Bus read into rd and rr
  task automatic rdReg(input logic [21:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    rready <= 1'b0;
    rd = rdata[7:0];
    rr = rresp;
  endtask
  // Bounded wait: 0 reset, 1 release, 2 interrupt, 3 cause
  task automatic waitHi(input int sel, input logic [7:0] exp, input string m);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < 40 && !hit; n++) begin
      @(posedge clock);
      #1;
      hit = sel == 0 ? monitorResetReq : sel == 1 ? !monitorResetReq :
            sel == 2 ? monitorIrq : resetCauseSet;
    end
    chk({7'h0, hit}, exp, m);
  endtask
  // Non-monitor reset with a new option byte
  task automatic otherRst(input logic [7:0] opt);
    @(posedge clock);
    otherResetReq <= 1'b1;
    optionByte <= opt;
    repeat (2) @(posedge clock);
    otherResetReq <= 1'b0;
    repeat (4) @(posedge clock);
    waitHi(1, 8'h01, "release after reset");
  endtask
  task automatic setVdd(input logic [15:0] v);
    @(posedge clock);
    vddMv <= v;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog
  initial begin
    #400000;
    n_fail++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_n, otherResetReq, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    optionByte = 8'h16;
    vddMv = HIGH;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      otherRst(rows[i].opt);
      rdReg(LVL);
      chk(rd, rows[i].lvl, "level reset value");
      rdReg(CTRL);
      chk(rd, 8'h00, "control reset value");
      rdReg(OPT);
      chk(rd, rows[i].opt, "option readback");
      setVdd(LOW);
      waitHi(rows[i].ev, rows[i].flag, "event on low supply");
      rdReg(CTRL);
      chk(rd, rows[i].flag, "flag with low supply");
      setVdd(HIGH);
      repeat (40) @(posedge clock);
      $display("mode row %0d done", i);
    end
    otherRst(8'h16);
    setVdd(MID);
    waitHi(2, 8'h01, "upper crossing interrupt");
    rdReg(LVL);
    chk(rd, 8'h81, "level after interrupt");
    wrReg(LVL, 8'h00);
    chk({6'h0, rr}, {6'h0, `RESP_OKAY}, "blocked write response");
    rdReg(LVL);
    chk(rd, 8'h81, "level write blocked");
    wrReg(CTRL, 8'hFF);
    rdReg(CTRL);
    chk(rd, 8'h82, "enable set, read-only bits");
    wrReg(LVL, 8'h00);
    rdReg(LVL);
    chk(rd, 8'h00, "level write accepted");
    rdReg(CTRL);
    chk(rd, 8'h83, "flag on upper level");
    wrReg(CTRL, 8'h00);
    repeat (30) @(posedge clock);
    rdReg(LVL);
    chk(rd, 8'h81, "interrupt after unmask");
    setVdd(LOW);
    waitHi(3, 8'h01, "monitor reset cause");
    rdReg(LVL);
    chk(rd, 8'h80, "level kept over monitor reset");
    rdReg(CTRL);
    chk(rd, 8'h01, "control kept over monitor reset");
    setVdd(HIGH);
    waitHi(1, 8'h01, "release above upper");
    $display("interrupt and reset sequence done");
    wrReg(CTRL, 8'h80);
    otherRst(8'h16);
    rdReg(CTRL);
    chk(rd, 8'h00, "enable cleared by other reset");
    rdReg(LVL);
    chk(rd, 8'h00, "level reloaded");
    rdReg(22'h000100);
    chk({6'h0, rr}, {6'h0, `RESP_DECERR}, "unmapped response");
    chk(rd, 8'h00, "unmapped data");
    wrReg(22'h000100, 8'h00);
    chk({6'h0, rr}, {6'h0, `RESP_DECERR}, "unmapped write response");
    optionByte <= 8'h06;
    @(posedge clock);
    #1;
    chk({7'h0, optionFault}, 8'h01, "fixed bit fault");
    $display("reset and bus tests done");
    end_sim();
  end
endmodule
`default_nettype wire
